// ### core/pief_top.sv
// peripheral interrupt enable and request flag logic with apb registers
//
// Operation
// - no peripheral interrupt reaches the core unless the global peripheral enable is set.
// - enable bit 7 gates the oscillator failure interrupt, 1 enables.
// - enable bit 6 gates comparator two (larger variant only), bit 5 comparator one.
// - enable bit 4 gates the nonvolatile write completion interrupt.
// - enable bit 3 gates the serial port bus collision interrupt.
// - all implemented enable and request bits clear to zero on every reset.
// - each request flag apart from rx and tx sets on its source event whatever the enables; rx and tx follow their level inputs.
// - request bits 7..0 are timer1 gate, converter, rx, tx, sync port, capture, timer2, timer1 ovf; rx and tx read-only.
// - the five upper enable bits are read and write, bit 6 only on the larger variant.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module pief_top #(
    parameter bit HAS_CMP_TWO = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] enable_src_event,
    input wire logic [7:0] request_src_event,
    input wire logic serial_rx_level,
    input wire logic serial_tx_level,
    output logic core_irq,
    output logic status_irq
);

    // ========================================
    // state
    pief_pkg::pief_state_t st_reg;
    pief_pkg::pief_state_t st_next;
    logic [4:0] en_flag_reg;
    logic [4:0] en_flag_next;
    logic wr_go;
    logic rd_go;
    logic wr_low;
    logic [7:0] en_mask;
    logic [7:0] wr_byte;
    logic [12:0] pending;
    logic core_req;
    logic [12:0] raw_events;

    // writable enable bits, comparator two only on the larger variant
    assign en_mask = HAS_CMP_TWO ? pief_pkg::ENABLE_TWO_MASK
                                 : (pief_pkg::ENABLE_TWO_MASK & ~(8'h01 << pief_pkg::EN_CMP_TWO));
    assign wr_go = psel & penable & pwrite & ~st_reg.pready;
    assign rd_go = psel & penable & ~pwrite & ~st_reg.pready;
    assign wr_low = wr_go & pstrb[0];
    assign wr_byte = pwdata[7:0];

    // per-source gating: enable flags with own enable, request_one flags ungated, then both global enables
    assign pending = {en_flag_reg, st_reg.request_one}
                   & {st_reg.enable_two[7:3], 8'hFF};
    assign core_req = (|pending) & st_reg.core_ctrl[pief_pkg::CTL_PERIPH_EN]
                    & st_reg.core_ctrl[pief_pkg::CTL_GLOBAL_EN];
    assign raw_events = {enable_src_event, request_src_event};

    // ========================================
    // next state
    always_comb begin
        st_next = st_reg;
        en_flag_next = en_flag_reg | enable_src_event;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (wr_low && paddr == pief_pkg::ADDR_ENABLE_TWO) begin
            st_next.enable_two = wr_byte & en_mask;
        end
        if (wr_low && paddr == pief_pkg::ADDR_REQUEST_ONE) begin
            st_next.request_one = (wr_byte & pief_pkg::REQUEST_SW_MASK)
                                | (st_reg.request_one & ~pief_pkg::REQUEST_SW_MASK);
        end
        if (wr_low && paddr == pief_pkg::ADDR_CORE_CTRL) begin
            st_next.core_ctrl = wr_byte & pief_pkg::CORE_CTRL_MASK;
        end
        if (wr_go && pstrb[0] && paddr == pief_pkg::ADDR_IRQ_ENABLE) begin
            st_next.irq_enable = pwdata[12:0];
        end
        if (wr_go && paddr == pief_pkg::ADDR_IRQ_CLEAR) begin
            st_next.irq_status = st_reg.irq_status & ~pwdata[12:0];
        end
        // hardware sets win over software writes in the same cycle
        st_next.request_one = st_next.request_one | request_src_event;
        st_next.request_one[pief_pkg::RQ_SERIAL_RX] = serial_rx_level;
        st_next.request_one[pief_pkg::RQ_SERIAL_TX] = serial_tx_level;
        st_next.irq_status = st_next.irq_status | raw_events;
        if (rd_go || wr_go) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            case (paddr)
                pief_pkg::ADDR_ENABLE_TWO: st_next.prdata[7:0] = st_reg.enable_two;
                pief_pkg::ADDR_REQUEST_ONE: st_next.prdata[7:0] = st_reg.request_one;
                pief_pkg::ADDR_CORE_CTRL: st_next.prdata[7:0] = st_reg.core_ctrl;
                pief_pkg::ADDR_IRQ_STATUS: st_next.prdata[12:0] = st_reg.irq_status;
                pief_pkg::ADDR_IRQ_CLEAR: st_next.prdata = 32'h0000_0000;
                pief_pkg::ADDR_IRQ_ENABLE: st_next.prdata[12:0] = st_reg.irq_enable;
                default: st_next.pslverr = 1'b1;
            endcase
        end
        st_next.core_irq = core_req;
        st_next.status_irq = |(st_reg.irq_status & st_reg.irq_enable);
    end

    // ========================================
    // registers, all cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.enable_two <= pief_pkg::ENABLE_TWO_RESET;
            st_reg.request_one <= pief_pkg::REQUEST_RESET;
            en_flag_reg <= 5'h00;
        end else begin
            st_reg <= st_next;
            en_flag_reg <= en_flag_next;
        end
    end

    // outputs straight from the state record
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign core_irq = st_reg.core_irq;
    assign status_irq = st_reg.status_irq;

    // ========================================
    // assertions
    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(st_reg.core_ctrl[pief_pkg::CTL_PERIPH_EN]) |-> !core_irq)
        else $error("interrupt without peripheral enable");
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.enable_two[2:0] == 3'h0)
        else $error("unimplemented enable bits set");
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_low && paddr == pief_pkg::ADDR_ENABLE_TWO
        |=> st_reg.enable_two[7:3] == ($past(pwdata[7:3]) & en_mask[7:3]))
        else $error("enable write lost");
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        request_src_event[0] |=> st_reg.request_one[0])
        else $error("flag not set by event");
    a_rx_readonly: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> st_reg.request_one[pief_pkg::RQ_SERIAL_RX] == $past(serial_rx_level))
        else $error("rx flag not tracking source");
    a_gate_all: assert property (@(posedge pclk) disable iff (!presetn)
        core_irq |-> $past(|pending))
        else $error("request without pending source");
    a_osc_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pending[12] |-> st_reg.enable_two[pief_pkg::EN_OSC_FAIL])
        else $error("oscillator fail ungated");
    a_cmp_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pending[11] |-> st_reg.enable_two[pief_pkg::EN_CMP_TWO])
        else $error("comparator two ungated");
    a_nvm_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pending[9] |-> st_reg.enable_two[pief_pkg::EN_NVM_DONE])
        else $error("nvm done ungated");
    a_coll_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pending[8] |-> st_reg.enable_two[pief_pkg::EN_BUS_COLL])
        else $error("bus collision ungated");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");

    c_core_irq: cover property (@(posedge pclk) disable iff (!presetn) core_irq);
    c_status_irq: cover property (@(posedge pclk) disable iff (!presetn) status_irq);
    c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // pief_top

// ### include/pief_pkg.sv
// package for the peripheral interrupt enable and flag block
package pief_pkg;

    // ========================================
    // register byte addresses
    localparam logic [11:0] ADDR_ENABLE_TWO = 12'h000;
    localparam logic [11:0] ADDR_REQUEST_ONE = 12'h004;
    localparam logic [11:0] ADDR_CORE_CTRL = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h010;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h014;

    // ========================================
    // field layout
    localparam int EN_OSC_FAIL = 7;
    localparam int EN_CMP_TWO = 6;
    localparam int EN_CMP_ONE = 5;
    localparam int EN_NVM_DONE = 4;
    localparam int EN_BUS_COLL = 3;
    localparam logic [7:0] ENABLE_TWO_MASK = 8'hF8;
    localparam int RQ_SERIAL_RX = 5;
    localparam int RQ_SERIAL_TX = 4;
    localparam logic [7:0] REQUEST_SW_MASK = 8'hCF;
    localparam int CTL_GLOBAL_EN = 7;
    localparam int CTL_PERIPH_EN = 6;
    localparam logic [7:0] CORE_CTRL_MASK = 8'hC0;

    // ========================================
    // reset values
    localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;
    localparam logic [7:0] REQUEST_RESET = 8'h00;

    // all block state in one record, apart from the enable flags in en_flag_reg
    typedef struct packed {
        logic [7:0] enable_two;
        logic [7:0] request_one;
        logic [7:0] core_ctrl;
        logic [12:0] irq_status;
        logic [12:0] irq_enable;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic core_irq;
        logic status_irq;
    } pief_state_t;

endpackage

// ### testbench/peripheral_interrupt_enable_flags_test.sv
// self-checking bench for the peripheral interrupt enable and flag block
`timescale 1ns/10ps
module peripheral_interrupt_enable_flags_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_irq, status_irq, err;
    logic serial_rx_level, serial_tx_level;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [4:0] enable_src_event;
    logic [7:0] request_src_event;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    pief_top pief_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enable_src_event(enable_src_event),
        .request_src_event(request_src_event), .serial_rx_level(serial_rx_level),
        .serial_tx_level(serial_tx_level), .core_irq(core_irq), .status_irq(status_irq));

    // ========================================
    // clock, inputs at time zero, cycle limit
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, serial_rx_level, serial_tx_level} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        enable_src_event = 5'h00;
        request_src_event = 8'h00;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    // ========================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task do_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t apb answer missing", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task lvl(input logic got_is_core, input logic exp, input string m);
        repeat (3) @(posedge pclk);
        #1;
        chk({31'h0, got_is_core ? core_irq : status_irq}, {31'h0, exp}, m);
        @(posedge pclk);
    endtask
    task pulse(input logic [4:0] e, input logic [7:0] r);
        enable_src_event <= e;
        request_src_event <= r;
        @(posedge pclk);
        enable_src_event <= 5'h00;
        request_src_event <= 8'h00;
        @(posedge pclk);
    endtask

    // ========================================
    // scenarios
    task test_regs;
        apb(1'b1, pief_pkg::ADDR_ENABLE_TWO, 32'hFF);
        apb(1'b0, pief_pkg::ADDR_ENABLE_TWO, 32'h0);
        chk(rd, 32'hF8, "enable rw");
        apb(1'b1, pief_pkg::ADDR_REQUEST_ONE, 32'hFF);
        apb(1'b0, pief_pkg::ADDR_REQUEST_ONE, 32'h0);
        chk(rd, 32'hCF, "request rw");
        serial_rx_level <= 1'b1;
        serial_tx_level <= 1'b1;
        apb(1'b1, pief_pkg::ADDR_REQUEST_ONE, 32'h00);
        apb(1'b0, pief_pkg::ADDR_REQUEST_ONE, 32'h0);
        chk(rd, 32'h30, "rx tx levels");
        {serial_rx_level, serial_tx_level} <= 2'b00;
        do_reset();
        apb(1'b0, pief_pkg::ADDR_ENABLE_TWO, 32'h0);
        chk(rd, 32'h00, "enable reset");
        apb(1'b0, pief_pkg::ADDR_REQUEST_ONE, 32'h0);
        chk(rd, 32'h00, "request reset");
        $display("test regs done");
    endtask
    task test_core;
        apb(1'b1, pief_pkg::ADDR_REQUEST_ONE, 32'h00);
        apb(1'b0, pief_pkg::ADDR_REQUEST_ONE, 32'h0);
        chk(rd, 32'h00, "flags clear before enable");
        pulse(5'h00, 8'h02);
        lvl(1'b1, 1'b0, "no global");
        apb(1'b0, pief_pkg::ADDR_REQUEST_ONE, 32'h0);
        chk(rd, 32'h02, "flag set");
        apb(1'b1, pief_pkg::ADDR_CORE_CTRL, 32'h40);
        lvl(1'b1, 1'b0, "periph only");
        apb(1'b1, pief_pkg::ADDR_CORE_CTRL, 32'hC0);
        lvl(1'b1, 1'b1, "both set");
        apb(1'b1, pief_pkg::ADDR_REQUEST_ONE, 32'h00);
        lvl(1'b1, 1'b0, "flag cleared");
        pulse(5'h10, 8'h00);
        lvl(1'b1, 1'b0, "osc fail off");
        apb(1'b1, pief_pkg::ADDR_ENABLE_TWO, 32'h80);
        lvl(1'b1, 1'b1, "osc fail on");
        $display("test core done");
    endtask
    task test_status;
        apb(1'b0, pief_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1002, "status");
        apb(1'b1, pief_pkg::ADDR_IRQ_ENABLE, 32'h0002);
        lvl(1'b0, 1'b1, "status irq");
        apb(1'b1, pief_pkg::ADDR_IRQ_CLEAR, 32'h1FFF);
        lvl(1'b0, 1'b0, "status clear");
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        $display("test status done");
    endtask

    // ========================================
    // closing report
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        test_regs();
        test_core();
        test_status();
        test_done();
    end
endmodule // peripheral_interrupt_enable_flags_test
